//--- hw/port_mux_consts.vh
// constants for the port a / port b alternate function override logic
// assumes inclusion by bare name from the design files under hw/
`ifndef PORT_MUX_CONSTS_VH
`define PORT_MUX_CONSTS_VH

// ----------------------------------------------------------------
// port widths and bit positions
// ----------------------------------------------------------------
`define PORTA_WIDTH 8
`define PORTB_HI_BIT 7
`define PORTB_LO_BIT 3
`define PORTB_SCK_BIT 7
`define PORTB_MISO_BIT 6
`define PORTB_MOSI_BIT 5
`define PORTB_SS_BIT 4
`define PORTB_OCA_BIT 3

// ----------------------------------------------------------------
// pin-change source numbering
// ----------------------------------------------------------------
`define PIN_CHANGE_PORTA_BASE 0
`define PIN_CHANGE_PORTB_BASE 11

// ----------------------------------------------------------------
// pull-up pattern {dir, out, pull-up disable} that turns the pull-up on
// ----------------------------------------------------------------
`define PULLUP_ON_PATTERN 3'h2

// ----------------------------------------------------------------
// constant override values
// ----------------------------------------------------------------
`define OVR_OFF 1'b0
`define OVR_ON 1'b1

`endif

//--- hw/pin_override_merge.v
// per-pin merge of override signals with the port register bits
// assumes override signals come from peripherals in the same domain
`timescale 1ns/10ps
`include "port_mux_consts.vh"

module pin_override_merge #(
   parameter WIDTH = 8
) (
   input wire [WIDTH-1:0] pin_dir_bit_in,
   input wire [WIDTH-1:0] pin_out_bit_in,
   input wire global_pullup_disable_in,
   input wire sleep_clamp_in,
   input wire [WIDTH-1:0] pullup_override_en_in,
   input wire [WIDTH-1:0] pullup_override_val_in,
   input wire [WIDTH-1:0] dir_override_en_in,
   input wire [WIDTH-1:0] dir_override_val_in,
   input wire [WIDTH-1:0] value_override_en_in,
   input wire [WIDTH-1:0] value_override_val_in,
   input wire [WIDTH-1:0] din_enable_override_en_in,
   input wire [WIDTH-1:0] din_enable_override_val_in,
   output wire [WIDTH-1:0] pullup_out,
   output wire [WIDTH-1:0] drive_en_out,
   output wire [WIDTH-1:0] drive_val_out,
   output wire [WIDTH-1:0] din_en_out
);

   // ----------------------------------------------------------------
   // per-pin merge
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         assign pullup_out[i] = pullup_override_en_in[i] ? pullup_override_val_in[i] :
            ({pin_dir_bit_in[i], pin_out_bit_in[i], global_pullup_disable_in}
             == `PULLUP_ON_PATTERN);
         assign drive_en_out[i] = dir_override_en_in[i] ? dir_override_val_in[i] :
            pin_dir_bit_in[i];
         assign drive_val_out[i] = value_override_en_in[i] ? value_override_val_in[i] :
            pin_out_bit_in[i];
         assign din_en_out[i] = din_enable_override_en_in[i] ?
            din_enable_override_val_in[i] : ~sleep_clamp_in;
      end
   endgenerate

endmodule // pin_override_merge

//--- hw/port_a_b_alt_function_override.v
// alternate function override network for port a and port b bits 7..3
// assumes port registers, spi, timer 0, adc and pin-change logic
// share the i/o clock; the network itself is combinational
`timescale 1ns/10ps
`include "port_mux_consts.vh"

module port_a_b_alt_function_override #(
   parameter PA_WIDTH = `PORTA_WIDTH
) (
   input wire ref_clk_in,
   input wire srst_in,
   input wire global_pullup_disable_in,
   input wire sleep_clamp_in,
   input wire [PA_WIDTH-1:0] porta_dir_in,
   input wire [PA_WIDTH-1:0] porta_out_in,
   input wire [PA_WIDTH-1:0] porta_pad_in,
   input wire [PA_WIDTH-1:0] pin_change_mask_porta_in,
   input wire pin_change_group0_en_in,
   input wire [PA_WIDTH-1:0] adc_din_disable_bit_in,
   input wire [7:3] portb_dir_in,
   input wire [7:3] portb_out_in,
   input wire [7:3] portb_pad_in,
   input wire [7:3] pin_change_mask_portb_in,
   input wire pin_change_group1_en_in,
   input wire spi_enable_in,
   input wire spi_master_in,
   input wire spi_sck_drive_in,
   input wire spi_master_data_drive_in,
   input wire spi_slave_data_drive_in,
   input wire timer0_compare_a_en_in,
   input wire timer0_compare_a_out_in,
   input wire timer0_compare_b_en_in,
   input wire timer0_compare_b_out_in,
   output wire [PA_WIDTH-1:0] porta_pullup_out,
   output wire [PA_WIDTH-1:0] porta_drive_en_out,
   output wire [PA_WIDTH-1:0] porta_drive_val_out,
   output wire [PA_WIDTH-1:0] porta_din_en_out,
   output wire [7:3] portb_pullup_out,
   output wire [7:3] portb_drive_en_out,
   output wire [7:3] portb_drive_val_out,
   output wire [7:3] portb_din_en_out,
   output wire [PA_WIDTH-1:0] adc_channel_out,
   output wire [PA_WIDTH-1:0] pin_change_src_porta_out,
   output wire [4:0] pin_change_src_portb_out,
   output wire spi_sck_sense_out,
   output wire spi_master_data_sense_out,
   output wire spi_slave_data_sense_out,
   output wire spi_slave_select_n_out,
   output wire spi_slave_active_out,
   output wire comparator_neg_out
);

   // ----------------------------------------------------------------
   // spi mode decode
   // ----------------------------------------------------------------
   // force-input condition for a pin that the spi turns round
   function force_input;
      input enable;
      input master;
      input input_in_master;
      begin
         force_input = enable & (master == input_in_master);
      end
   endfunction

   wire spi_master_mode;
   wire spi_slave_mode;
   assign spi_master_mode = spi_enable_in & spi_master_in;
   assign spi_slave_mode = spi_enable_in & ~spi_master_in;

   // ----------------------------------------------------------------
   // port a override signals
   // ----------------------------------------------------------------
   wire [PA_WIDTH-1:0] pa_pullup_override_en;
   wire [PA_WIDTH-1:0] pa_pullup_override_val;
   wire [PA_WIDTH-1:0] pa_dir_override_en;
   wire [PA_WIDTH-1:0] pa_dir_override_val;
   wire [PA_WIDTH-1:0] pa_value_override_en;
   wire [PA_WIDTH-1:0] pa_value_override_val;
   wire [PA_WIDTH-1:0] pa_din_enable_override_en;
   wire [PA_WIDTH-1:0] pa_din_enable_override_val;

   genvar n;
   generate
      for (n = 0; n < PA_WIDTH; n = n + 1) begin : g_pa
         assign pa_pullup_override_en[n] = `OVR_OFF;
         assign pa_pullup_override_val[n] = `OVR_OFF;
         assign pa_dir_override_en[n] = `OVR_OFF;
         assign pa_dir_override_val[n] = `OVR_OFF;
         assign pa_value_override_en[n] = `OVR_OFF;
         assign pa_value_override_val[n] = `OVR_OFF;
         assign pa_din_enable_override_val[n] =
            pin_change_mask_porta_in[n] & pin_change_group0_en_in;
         assign pa_din_enable_override_en[n] =
            pa_din_enable_override_val[n] | adc_din_disable_bit_in[n];
      end
   endgenerate

   // ----------------------------------------------------------------
   // port b override signals, bits 7..3
   // ----------------------------------------------------------------
   wire sck_forced;
   wire miso_forced;
   wire mosi_forced;
   wire ss_forced;
   // master leaves clock to dir bit
   assign sck_forced = force_input(spi_enable_in, spi_master_in, `OVR_OFF);
   // slave leaves miso to dir bit
   assign miso_forced = force_input(spi_enable_in, spi_master_in, `OVR_ON);
   // master leaves mosi to dir bit
   assign mosi_forced = force_input(spi_enable_in, spi_master_in, `OVR_OFF);
   // master leaves select to dir bit
   assign ss_forced = force_input(spi_enable_in, spi_master_in, `OVR_OFF);

   wire [7:3] pb_forced;
   assign pb_forced = {sck_forced, miso_forced, mosi_forced, ss_forced, `OVR_OFF};

   wire [7:3] pb_pullup_override_en;
   wire [7:3] pb_pullup_override_val;
   wire [7:3] pb_dir_override_en;
   wire [7:3] pb_dir_override_val;
   wire [7:3] pb_value_override_en;
   wire [7:3] pb_value_override_val;
   wire [7:3] pb_din_enable_override_en;
   wire [7:3] pb_din_enable_override_val;

   genvar b;
   generate
      for (b = `PORTB_LO_BIT; b <= `PORTB_HI_BIT; b = b + 1) begin : g_pb
         assign pb_pullup_override_en[b] = pb_forced[b];
         assign pb_pullup_override_val[b] = portb_out_in[b] & ~global_pullup_disable_in;
         // forced pins turn the driver off
         assign pb_dir_override_en[b] = pb_forced[b];
         assign pb_dir_override_val[b] = `OVR_OFF;
         assign pb_din_enable_override_en[b] =
            pin_change_mask_portb_in[b] & pin_change_group1_en_in;
         assign pb_din_enable_override_val[b] = `OVR_ON;
      end
   endgenerate

   // ----------------------------------------------------------------
   // port b value overrides
   // ----------------------------------------------------------------
   // spi lines drive the pin only where the spi owns the output
   assign pb_value_override_en[`PORTB_SCK_BIT] = spi_master_mode;
   assign pb_value_override_val[`PORTB_SCK_BIT] = spi_sck_drive_in;
   assign pb_value_override_en[`PORTB_MISO_BIT] = spi_slave_mode;
   assign pb_value_override_val[`PORTB_MISO_BIT] = spi_slave_data_drive_in;
   assign pb_value_override_en[`PORTB_MOSI_BIT] = spi_master_mode;
   assign pb_value_override_val[`PORTB_MOSI_BIT] = spi_master_data_drive_in;
   assign pb_value_override_en[`PORTB_SS_BIT] = timer0_compare_b_en_in;
   assign pb_value_override_val[`PORTB_SS_BIT] = timer0_compare_b_out_in;
   assign pb_value_override_en[`PORTB_OCA_BIT] = timer0_compare_a_en_in;
   assign pb_value_override_val[`PORTB_OCA_BIT] = timer0_compare_a_out_in;

   // ----------------------------------------------------------------
   // merge with port registers
   // ----------------------------------------------------------------
   // no storage in the path
   pin_override_merge #(
      .WIDTH(PA_WIDTH)
   ) u_merge_a (
      .pin_dir_bit_in(porta_dir_in),
      .pin_out_bit_in(porta_out_in),
      .global_pullup_disable_in(global_pullup_disable_in),
      .sleep_clamp_in(sleep_clamp_in),
      .pullup_override_en_in(pa_pullup_override_en),
      .pullup_override_val_in(pa_pullup_override_val),
      .dir_override_en_in(pa_dir_override_en),
      .dir_override_val_in(pa_dir_override_val),
      .value_override_en_in(pa_value_override_en),
      .value_override_val_in(pa_value_override_val),
      .din_enable_override_en_in(pa_din_enable_override_en),
      .din_enable_override_val_in(pa_din_enable_override_val),
      .pullup_out(porta_pullup_out),
      .drive_en_out(porta_drive_en_out),
      .drive_val_out(porta_drive_val_out),
      .din_en_out(porta_din_en_out)
   );

   pin_override_merge #(
      .WIDTH(5)
   ) u_merge_b (
      .pin_dir_bit_in(portb_dir_in),
      .pin_out_bit_in(portb_out_in),
      .global_pullup_disable_in(global_pullup_disable_in),
      .sleep_clamp_in(sleep_clamp_in),
      .pullup_override_en_in(pb_pullup_override_en),
      .pullup_override_val_in(pb_pullup_override_val),
      .dir_override_en_in(pb_dir_override_en),
      .dir_override_val_in(pb_dir_override_val),
      .value_override_en_in(pb_value_override_en),
      .value_override_val_in(pb_value_override_val),
      .din_enable_override_en_in(pb_din_enable_override_en),
      .din_enable_override_val_in(pb_din_enable_override_val),
      .pullup_out(portb_pullup_out),
      .drive_en_out(portb_drive_en_out),
      .drive_val_out(portb_drive_val_out),
      .din_en_out(portb_din_en_out)
   );

   // ----------------------------------------------------------------
   // inputs to the peripherals
   // ----------------------------------------------------------------
   // a disabled input buffer clamps the digital input low
   wire [PA_WIDTH-1:0] pa_alt_digital_in;
   wire [7:3] pb_alt_digital_in;
   assign pa_alt_digital_in = porta_pad_in & porta_din_en_out;
   assign pb_alt_digital_in = portb_pad_in & portb_din_en_out;

   assign adc_channel_out = porta_pad_in;
   assign pin_change_src_porta_out = pa_alt_digital_in;
   assign pin_change_src_portb_out = pb_alt_digital_in[7:3];

   assign spi_sck_sense_out = pb_alt_digital_in[`PORTB_SCK_BIT];
   assign spi_master_data_sense_out = pb_alt_digital_in[`PORTB_MISO_BIT];
   assign spi_slave_data_sense_out = pb_alt_digital_in[`PORTB_MOSI_BIT];
   assign spi_slave_select_n_out = pb_alt_digital_in[`PORTB_SS_BIT];
   assign spi_slave_active_out = spi_slave_mode & ~pb_alt_digital_in[`PORTB_SS_BIT];
   assign comparator_neg_out = portb_pad_in[`PORTB_OCA_BIT];

endmodule // port_a_b_alt_function_override

//--- testbench/periph_far_model.sv
// far-side model of the spi shifter and timer 0 compare outputs
// assumes the bench clock; values move just after each rising edge
`timescale 1ns/10ps
module periph_far_model (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   output logic sck_drive_out,
   output logic mst_data_out,
   output logic slv_data_out,
   output logic cmp_a_out,
   output logic cmp_b_out
);
   logic [7:0] shift;
   // ----------------------------------------
   // pattern that changes every cycle
   // ----------------------------------------
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         shift <= 8'h5a;
      end else begin
         shift <= {shift[6:0], shift[7] ^ shift[5] ^ shift[4] ^ shift[3]};
      end
   end
   assign {sck_drive_out, mst_data_out, slv_data_out, cmp_a_out, cmp_b_out} = shift[4:0];
endmodule // periph_far_model

//--- testbench/port_mux_chk.sv
// checker for the port a / port b override network
// assumes binding to the top module; all outputs are combinational
`timescale 1ns/10ps
module port_mux_chk #(
   parameter PA_WIDTH = 8
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic global_pullup_disable_in,
   input wire logic [PA_WIDTH-1:0] porta_dir_in,
   input wire logic [PA_WIDTH-1:0] porta_out_in,
   input wire logic [PA_WIDTH-1:0] porta_pad_in,
   input wire logic [PA_WIDTH-1:0] porta_pullup_out,
   input wire logic [PA_WIDTH-1:0] porta_drive_en_out,
   input wire logic [PA_WIDTH-1:0] adc_channel_out,
   input wire logic [7:3] portb_dir_in,
   input wire logic [7:3] portb_out_in,
   input wire logic [7:3] portb_pad_in,
   input wire logic [7:3] portb_pullup_out,
   input wire logic [7:3] portb_drive_en_out,
   input wire logic spi_enable_in,
   input wire logic spi_master_in,
   input wire logic spi_slave_select_n_out,
   input wire logic spi_slave_active_out,
   input wire logic comparator_neg_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   sequence slave_s; spi_enable_in && !spi_master_in; endsequence
   sequence master_s; spi_enable_in && spi_master_in; endsequence
   pa_dir_pass_a: assert property (porta_drive_en_out == porta_dir_in)
      else $error("port a direction overridden");
   pa_pullup_a: assert property (porta_pullup_out ==
      (~porta_dir_in & porta_out_in & {PA_WIDTH{!global_pullup_disable_in}}))
      else $error("port a pull-up wrong");
   adc_path_a: assert property (adc_channel_out == porta_pad_in)
      else $error("adc channel not the pad");
   slave_force_a: assert property (slave_s |-> portb_drive_en_out[7:4] ==
      {1'b0, portb_dir_in[6], 2'b00}) else $error("slave mode directions wrong");
   master_force_a: assert property (master_s |-> portb_drive_en_out[7:4] ==
      (portb_dir_in[7:4] & 4'hb)) else $error("master mode directions wrong");
   forced_pullup_a: assert property (slave_s |-> portb_pullup_out[7] ==
      (portb_out_in[7] && !global_pullup_disable_in)) else $error("forced pin pull-up wrong");
   spi_off_a: assert property (!spi_enable_in |-> portb_drive_en_out == portb_dir_in)
      else $error("spi off still forces direction");
   select_active_a: assert property (spi_slave_active_out ==
      (spi_enable_in && !spi_master_in && !spi_slave_select_n_out))
      else $error("slave active wrong");
   comparator_a: assert property (comparator_neg_out == portb_pad_in[3])
      else $error("comparator input not the pad");
   no_latency_a: assert property ($changed(porta_pad_in) |-> $changed(adc_channel_out))
      else $error("output lags its input");
endmodule // port_mux_chk

bind port_a_b_alt_function_override port_mux_chk #(.PA_WIDTH(PA_WIDTH)) port_mux_chk_i (
   .ref_clk_in(ref_clk_in), .srst_in(srst_in), .global_pullup_disable_in(global_pullup_disable_in),
   .porta_dir_in(porta_dir_in), .porta_out_in(porta_out_in), .porta_pad_in(porta_pad_in),
   .porta_pullup_out(porta_pullup_out), .porta_drive_en_out(porta_drive_en_out),
   .adc_channel_out(adc_channel_out), .portb_dir_in(portb_dir_in), .portb_out_in(portb_out_in),
   .portb_pad_in(portb_pad_in), .portb_pullup_out(portb_pullup_out),
   .portb_drive_en_out(portb_drive_en_out), .spi_enable_in(spi_enable_in),
   .spi_master_in(spi_master_in), .spi_slave_select_n_out(spi_slave_select_n_out),
   .spi_slave_active_out(spi_slave_active_out), .comparator_neg_out(comparator_neg_out));

//--- testbench/port_a_b_alt_function_override_tb.sv
// self-checking bench for the port a / port b override network
// assumes the far-side model supplies spi and compare output values
`timescale 1ns/10ps
module port_a_b_alt_function_override_tb;
   logic ref_clk_in, srst_in, pu_off, sleep, grp0, grp1, en, mst, cae, cbe;
   logic [7:0] pa_dir, pa_out, pa_pad, pa_mask, adc_dis;
   logic [7:3] pb_dir, pb_out, pb_pad, pb_mask;
   wire sck_d, mst_d, slv_d, cao, cbo, sck_s, mst_s, slv_s, ss_n, active, cmp_neg;
   wire [7:0] pa_pu, pa_den, pa_dval, pa_din, adc, pa_src;
   wire [7:3] pb_pu, pb_den, pb_dval, pb_din;
   wire [4:0] pb_src;
   int mismatches, comparisons;
   port_a_b_alt_function_override port_a_b_alt_function_override_i (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .global_pullup_disable_in(pu_off),
      .sleep_clamp_in(sleep), .porta_dir_in(pa_dir), .porta_out_in(pa_out), .porta_pad_in(pa_pad),
      .pin_change_mask_porta_in(pa_mask), .pin_change_group0_en_in(grp0),
      .adc_din_disable_bit_in(adc_dis), .portb_dir_in(pb_dir), .portb_out_in(pb_out),
      .portb_pad_in(pb_pad), .pin_change_mask_portb_in(pb_mask), .pin_change_group1_en_in(grp1),
      .spi_enable_in(en), .spi_master_in(mst), .spi_sck_drive_in(sck_d),
      .spi_master_data_drive_in(mst_d), .spi_slave_data_drive_in(slv_d),
      .timer0_compare_a_en_in(cae), .timer0_compare_a_out_in(cao), .timer0_compare_b_en_in(cbe),
      .timer0_compare_b_out_in(cbo), .porta_pullup_out(pa_pu), .porta_drive_en_out(pa_den),
      .porta_drive_val_out(pa_dval), .porta_din_en_out(pa_din), .portb_pullup_out(pb_pu),
      .portb_drive_en_out(pb_den), .portb_drive_val_out(pb_dval), .portb_din_en_out(pb_din),
      .adc_channel_out(adc), .pin_change_src_porta_out(pa_src), .pin_change_src_portb_out(pb_src),
      .spi_sck_sense_out(sck_s), .spi_master_data_sense_out(mst_s),
      .spi_slave_data_sense_out(slv_s), .spi_slave_select_n_out(ss_n),
      .spi_slave_active_out(active), .comparator_neg_out(cmp_neg));
   periph_far_model periph_far_model_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .sck_drive_out(sck_d), .mst_data_out(mst_d), .slv_data_out(slv_d),
      .cmp_a_out(cao), .cmp_b_out(cbo));
   // ----------------------------------------
   // expectations and comparison
   // ----------------------------------------
   function automatic logic [7:0] din_exp(input logic [7:0] oe, input logic [7:0] ov,
                                          input logic slp);
      return (oe & ov) | (~oe & {8{~slp}});
   endfunction
   function automatic logic [7:0] pu_exp(input logic [7:0] f, input logic [7:0] d,
                                         input logic [7:0] o, input logic p);
      return o & {8{~p}} & (f | ~d);
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic check_all;
      logic [7:0] f, ven, vval, pdin, bdin, bdir;
      f = en ? (mst ? 8'h08 : 8'h16) : 8'h00;
      ven = {3'h0, en & mst, en & ~mst, en & mst, cbe, cae};
      vval = {3'h0, sck_d, slv_d, mst_d, cbo, cao};
      bdir = {3'h0, pb_dir};
      pdin = din_exp((pa_mask & {8{grp0}}) | adc_dis, pa_mask & {8{grp0}}, sleep);
      bdin = din_exp({3'h0, pb_mask} & {8{grp1}}, 8'hff, sleep);
      check("pa_pullup", pa_pu, pu_exp(8'h00, pa_dir, pa_out, pu_off));
      check("pa_drive_en", pa_den, pa_dir);
      check("pa_drive_val", pa_dval & pa_dir, pa_out & pa_dir);
      check("pa_din_en", pa_din, pdin);
      check("adc", adc, pa_pad);
      check("pa_pcint", pa_src, pa_pad & pdin);
      check("pb_pullup", {3'h0, pb_pu}, pu_exp(f, bdir, {3'h0, pb_out}, pu_off));
      check("pb_drive_en", {3'h0, pb_den}, ~f & bdir);
      check("pb_drive_val", {3'h0, pb_dval & pb_den},
            ((ven & vval) | (~ven & {3'h0, pb_out})) & ~f & bdir);
      check("pb_din_en", {3'h0, pb_din}, bdin & 8'h1f);
      check("pb_pcint", {3'h0, pb_src}, {3'h0, pb_pad} & bdin);
      check("spi_sense", {4'h0, sck_s, mst_s, slv_s, ss_n},
            {4'h0, pb_pad[7:4] & bdin[4:1]});
      check("slave_active", {7'h0, active}, {7'h0, en & ~mst & ~(pb_pad[4] & bdin[1])});
      check("cmp_neg", {7'h0, cmp_neg}, {7'h0, pb_pad[3]});
   endtask
   task automatic drive(input int i);
      logic [63:0] r;
      r = {$urandom, $urandom};
      if (i < 8) begin
         // every spi mode, all port b pins output, select held low
         {r[7], r[3], r[2], r[6]} = {1'b0, i[0], i[1], i[2]};
         r[57:48] = 10'h3ff;
         r[59] = 1'b0;
      end
      {pu_off, sleep, grp0, grp1, en, mst, cae, cbe} <= r[7:0];
      pa_dir <= r[15:8];
      pa_out <= r[23:16];
      pa_pad <= r[31:24];
      pa_mask <= r[39:32];
      adc_dis <= r[47:40];
      pb_dir <= r[52:48];
      pb_out <= r[57:53];
      pb_pad <= r[62:58];
      pb_mask <= 5'($urandom);
   endtask
   task test_done;
      if (mismatches == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #10000;
      mismatches++;
      test_done;
   end
   initial begin
      mismatches = 0;
      comparisons = 0;
      srst_in = 1'b1;
      {pu_off, sleep, grp0, grp1, en, mst, cae, cbe} = 8'h00;
      {pa_dir, pa_out, pa_pad, pa_mask, adc_dis} = 40'h00_0000_0000;
      {pb_dir, pb_out, pb_pad, pb_mask} = 20'h0_0000;
      void'($urandom(86));
      repeat (2) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 400; i++) begin
         @(posedge ref_clk_in);
         drive(i);
         @(negedge ref_clk_in);
         check_all;
      end
      test_done;
   end
endmodule // port_a_b_alt_function_override_tb
